// File: hw/prog_word_lanes.v
// program address forming and byte lane steering for one program word
// assumes a 24-bit program word and 16-bit data side, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "psv_consts.vh"

module prog_word_lanes (
	// address sources
	input  wire        i_use_table,   // table op when high, window otherwise
	input  wire [7:0]  i_window_page, // window page register
	input  wire [7:0]  i_table_page,  // table page register
	input  wire [15:0] i_ea,          // effective address
	// table mode
	input  wire [1:0]  i_tbl_op,      // table operation code
	input  wire        i_tbl_byte,    // byte mode
	// data
	input  wire [23:0] i_pm_word,     // word read from program memory
	input  wire [15:0] i_wdata,       // data to write
	// results
	output reg  [23:0] o_pm_addr,     // program address
	output reg  [15:0] o_rdata,       // read data for the core
	output reg  [23:0] o_pm_wdata,    // write data placed on lanes
	output reg  [2:0]  o_pm_wbe       // write byte enables
);

	// address: table page or window page on top
	always @* begin
		if (i_use_table) begin
			o_pm_addr = {i_table_page, i_ea};
		end else begin
			// upper bit zero: page covers 32K words
			o_pm_addr = {1'b0, i_window_page, i_ea[14:0]};
		end
	end

	// read lane steering
	always @* begin
		o_rdata = i_pm_word[15:0];
		if (i_use_table) begin
			case (i_tbl_op)
				`TBL_READ_HIGH: begin
					// odd byte of the high half is a phantom zero
					if (i_tbl_byte && i_ea[0]) begin
						o_rdata = 16'h0000;
					end else begin
						o_rdata = {8'h00, i_pm_word[23:16]};
					end
				end
				default: begin
					if (i_tbl_byte) begin
						o_rdata = {8'h00, i_ea[0] ? i_pm_word[15:8] : i_pm_word[7:0]};
					end else begin
						o_rdata = i_pm_word[15:0];
					end
				end
			endcase
		end
	end

	// write lane steering
	always @* begin
		o_pm_wdata = 24'h000000;
		o_pm_wbe   = 3'h0;
		case (i_tbl_op)
			`TBL_WRITE_LOW: begin
				if (i_tbl_byte) begin
					o_pm_wdata = {8'h00, i_wdata[7:0], i_wdata[7:0]};
					o_pm_wbe   = i_ea[0] ? 3'h2 : 3'h1;
				end else begin
					o_pm_wdata = {8'h00, i_wdata};
					o_pm_wbe   = 3'h3;
				end
			end
			`TBL_WRITE_HIGH: begin
				o_pm_wdata = {i_wdata[7:0], 16'h0000};
				// odd byte is phantom, nothing written
				o_pm_wbe   = (i_tbl_byte && i_ea[0]) ? 3'h0 : 3'h4;
			end
			default: begin
				o_pm_wbe = 3'h0;
			end
		endcase
	end

endmodule // prog_word_lanes
`default_nettype wire

// File: hw/program_space_window.v
// program space window, table access and self programming sizing
// assumes a core that waits on ready, a program memory and a data ram
// that both return read data one cycle after their request, and an
// ahb-lite master that is the only master on the register bus
`timescale 1ns/1ps
`default_nettype none
`include "psv_consts.vh"

module program_space_window (
	// clock and reset
	input  wire        i_clk_sys,
	input  wire        i_rst_n,
	// ahb-lite register slave
	input  wire        i_hsel,
	input  wire [7:0]  i_haddr,
	input  wire [1:0]  i_htrans,
	input  wire        i_hwrite,
	input  wire [2:0]  i_hsize,
	input  wire [31:0] i_hwdata,
	input  wire        i_hready,
	output wire        o_hreadyout,
	output wire        o_hresp,
	output reg  [31:0] o_hrdata,
	// core data-space access
	input  wire        i_ds_req,
	input  wire [15:0] i_ds_ea,
	input  wire        i_ds_is_move,
	input  wire        i_rep_active,
	input  wire        i_rep_first,
	input  wire        i_rep_last,
	input  wire        i_rep_irq_exit,
	input  wire        i_rep_irq_reentry,
	output wire        o_ds_ready,
	output reg         o_ds_done,
	output reg  [15:0] o_ds_rdata,
	// core table access
	input  wire        i_tbl_req,
	input  wire [1:0]  i_tbl_op,
	input  wire        i_tbl_byte,
	input  wire [15:0] i_tbl_ea,
	input  wire [15:0] i_tbl_wdata,
	input  wire        i_normal_mode,
	output wire        o_tbl_ready,
	output reg         o_tbl_done,
	output reg  [15:0] o_tbl_rdata,
	// program memory
	output reg         o_pm_rd,
	output reg         o_pm_wr,
	output reg  [23:0] o_pm_addr,
	output reg  [23:0] o_pm_wdata,
	output reg  [2:0]  o_pm_wbe,
	input  wire [23:0] i_pm_rdata,
	// data ram
	output reg         o_ram_rd,
	output reg  [15:0] o_ram_addr,
	input  wire [15:0] i_ram_rdata,
	// self programming block sizes
	output wire [7:0]  o_write_block_instr,
	output wire [7:0]  o_write_block_bytes,
	output reg  [7:0]  o_erase_block_instr,
	// serial programming lines
	input  wire        i_prog_clock_line,
	input  wire        i_prog_data_line,
	output wire        o_prog_data_line,
	output wire        o_prog_data_line_oe
);

	// sequencer states
	localparam ST_IDLE  = 2'h0; // waiting for a request
	localparam ST_ISSUE = 2'h1; // memory answers the strobe
	localparam ST_CAPT  = 2'h2; // read data arrives
	localparam ST_XTRA  = 2'h3; // added stall cycles
	localparam [7:0] RST_CTRL = `RST_CPU_CONTROL; // reset image of cpu control

	// registers
	reg        win_en_q;        // window enable in cpu control
	reg [7:0]  window_page_q;   // const_window_page
	reg [7:0]  table_page_q;    // table_page
	reg [1:0]  erase_sel_q;     // erase_size_select
	reg [15:0] prog_shift_q;    // bits gathered from serial lines
	reg        prog_clk_prev_q; // previous serial clock level
	// bus data phase bookkeeping
	reg        bus_wr_q;        // write pending in data phase
	reg [7:0]  bus_addr_q;      // address of that write
	// sequencer
	reg [1:0]  state_q;
	reg [1:0]  xtra_q;          // extra cycles still owed
	reg        is_tbl_q;        // current job is a table op
	reg        is_win_q;        // current job reads program memory via window
	reg [1:0]  tbl_op_q;
	reg        tbl_byte_q;
	reg [15:0] ea_q;
	reg [15:0] wdata_q;

	// lane helper outputs
	wire [23:0] lane_addr;
	wire [15:0] lane_rdata;
	wire [23:0] lane_wdata;
	wire [2:0]  lane_wbe;

	// extra instruction cycles for a window access
	function [1:0] extra_cycles;
		input is_move;
		input rep_active;
		input rep_edge;
		begin
			if (!rep_active) begin
				extra_cycles = is_move ? `XTRA_MOVE : `XTRA_OTHER;
			end else if (rep_edge) begin
				extra_cycles = `XTRA_OTHER;
			end else begin
				extra_cycles = `XTRA_NONE;
			end
		end
	endfunction

	// erase block size from the select field
	function [7:0] erase_size;
		input [1:0] sel;
		begin
			case (sel)
				`ERASE_SEL_64:  erase_size = `ERASE_BLOCK_64;
				`ERASE_SEL_128: erase_size = `ERASE_BLOCK_128;
				default:        erase_size = `ERASE_BLOCK_32;
			endcase
		end
	endfunction

	// handshake and steering
	wire idle      = (state_q == ST_IDLE);
	wire tbl_go    = idle & i_tbl_req & i_normal_mode;
	// table requests have priority, so the window stays off while one runs
	wire ds_go     = idle & i_ds_req & ~i_tbl_req;
	wire rep_edge  = i_rep_first | i_rep_last | i_rep_irq_exit | i_rep_irq_reentry;
	wire win_hit   = i_ds_ea[`BIT_EA_TOP] & win_en_q & ~i_tbl_req;
	wire bus_phase = i_hsel & i_htrans[1] & i_hready;
	wire busy      = ~idle;

	assign o_ds_ready  = idle & ~i_tbl_req;
	assign o_tbl_ready = idle & i_normal_mode;
	assign o_hreadyout = 1'b1; // every access completes with no wait
	assign o_hresp     = 1'b0; // always okay, unmapped reads zero

	assign o_write_block_instr = `WRITE_BLOCK_INSTR;
	assign o_write_block_bytes = `WRITE_BLOCK_BYTES;

	// the data line is only listened to; answering is outside this block
	assign o_prog_data_line    = 1'b0;
	assign o_prog_data_line_oe = 1'b0;

	// live request while idle, so the strobe leaves on the take edge
	wire        lane_tbl  = idle ? i_tbl_req : is_tbl_q;
	wire [15:0] lane_ea   = idle ? (i_tbl_req ? i_tbl_ea : i_ds_ea) : ea_q;
	wire [1:0]  lane_op   = idle ? i_tbl_op : tbl_op_q;
	wire        lane_byte = idle ? i_tbl_byte : tbl_byte_q;
	wire [15:0] lane_wsrc = idle ? i_tbl_wdata : wdata_q;
	// address forming and lane steering
	prog_word_lanes u_lanes (
		.i_use_table   (lane_tbl),
		.i_window_page (window_page_q),
		.i_table_page  (table_page_q),
		.i_ea          (lane_ea),
		.i_tbl_op      (lane_op),
		.i_tbl_byte    (lane_byte),
		.i_pm_word     (i_pm_rdata),
		.i_wdata       (lane_wsrc),
		.o_pm_addr     (lane_addr),
		.o_rdata       (lane_rdata),
		.o_pm_wdata    (lane_wdata),
		.o_pm_wbe      (lane_wbe)
	);

	// register writes happen in the data phase
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			bus_wr_q      <= 1'b0;
			bus_addr_q    <= 8'h00;
			win_en_q      <= RST_CTRL[`BIT_WINDOW_ENABLE];
			window_page_q <= `RST_WINDOW_PAGE;
			table_page_q  <= `RST_TABLE_PAGE;
			erase_sel_q   <= `RST_ERASE_SEL;
		end else begin
			bus_wr_q   <= bus_phase & i_hwrite;
			bus_addr_q <= i_haddr;
			if (bus_wr_q) begin
				case (bus_addr_q)
					`OFS_CPU_CONTROL:       win_en_q      <= i_hwdata[`BIT_WINDOW_ENABLE];
					`OFS_CONST_WINDOW_PAGE: window_page_q <= i_hwdata[7:0];
					`OFS_TABLE_PAGE:        table_page_q  <= i_hwdata[7:0];
					`OFS_MEM_PROG_CONTROL:  erase_sel_q   <= i_hwdata[1:0];
					default:                win_en_q      <= win_en_q; // unmapped ignored
				endcase
			end
		end
	end

	// read data prepared in the address phase, stands in the data phase
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_hrdata <= 32'h00000000;
		end else if (bus_phase && !i_hwrite) begin
			case (i_haddr)
				`OFS_CPU_CONTROL:       o_hrdata <= {29'h0, win_en_q, 2'h0};
				`OFS_CONST_WINDOW_PAGE: o_hrdata <= {24'h0, window_page_q};
				`OFS_TABLE_PAGE:        o_hrdata <= {24'h0, table_page_q};
				`OFS_MEM_PROG_CONTROL:  o_hrdata <= {30'h0, erase_sel_q};
				`OFS_STATUS:            o_hrdata <= {8'h0, `WRITE_BLOCK_INSTR,
					erase_size(erase_sel_q), 7'h0, busy};
				`OFS_PROG_SHIFT:        o_hrdata <= {16'h0, prog_shift_q};
				default:                o_hrdata <= 32'h00000000;
			endcase
		end
	end

	// serial programming lines: data sampled on each clock rise
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			prog_clk_prev_q <= 1'b0;
			prog_shift_q    <= 16'h0000;
		end else begin
			prog_clk_prev_q <= i_prog_clock_line;
			if (i_prog_clock_line && !prog_clk_prev_q) begin
				prog_shift_q <= {prog_shift_q[14:0], i_prog_data_line};
			end
		end
	end

	// erase size output follows the select field
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_erase_block_instr <= `ERASE_BLOCK_32;
		end else begin
			o_erase_block_instr <= erase_size(erase_sel_q);
		end
	end

	// access sequencer
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_q     <= ST_IDLE;
			xtra_q      <= `XTRA_NONE;
			is_tbl_q    <= 1'b0;
			is_win_q    <= 1'b0;
			tbl_op_q    <= `TBL_READ_LOW;
			tbl_byte_q  <= 1'b0;
			ea_q        <= 16'h0000;
			wdata_q     <= 16'h0000;
			o_pm_rd     <= 1'b0;
			o_pm_wr     <= 1'b0;
			o_pm_addr   <= 24'h000000;
			o_pm_wdata  <= 24'h000000;
			o_pm_wbe    <= 3'h0;
			o_ram_rd    <= 1'b0;
			o_ram_addr  <= 16'h0000;
			o_ds_done   <= 1'b0;
			o_ds_rdata  <= 16'h0000;
			o_tbl_done  <= 1'b0;
			o_tbl_rdata <= 16'h0000;
		end else begin
			// strobes last one cycle
			o_pm_rd    <= 1'b0;
			o_pm_wr    <= 1'b0;
			o_ram_rd   <= 1'b0;
			o_ds_done  <= 1'b0;
			o_tbl_done <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (tbl_go) begin
						is_tbl_q   <= 1'b1;
						is_win_q   <= 1'b0;
						tbl_op_q   <= i_tbl_op;
						tbl_byte_q <= i_tbl_byte;
						ea_q       <= i_tbl_ea;
						wdata_q    <= i_tbl_wdata;
						xtra_q     <= `XTRA_NONE;
						state_q    <= ST_ISSUE;
						o_pm_addr  <= lane_addr;
						o_pm_wdata <= lane_wdata;
						o_pm_wbe   <= lane_wbe;
						if (i_tbl_op[1]) begin
							o_pm_wr <= 1'b1;
						end else begin
							o_pm_rd <= 1'b1;
						end
					end else if (ds_go) begin
						is_tbl_q <= 1'b0;
						is_win_q <= win_hit;
						ea_q     <= i_ds_ea;
						// ram path carries no added cycles
						xtra_q   <= win_hit ? extra_cycles(i_ds_is_move, i_rep_active,
							rep_edge) : `XTRA_NONE;
						state_q  <= ST_ISSUE;
						if (win_hit) begin
							o_pm_addr <= lane_addr;
							o_pm_rd   <= 1'b1;
						end else begin
							o_ram_addr <= i_ds_ea;
							o_ram_rd   <= 1'b1;
						end
					end
				end
				ST_ISSUE: begin
					// memory answers the strobe sent on the take edge
					state_q <= ST_CAPT;
				end
				ST_CAPT: begin
					if (is_tbl_q) begin
						// write ops return their data unchanged
						o_tbl_rdata <= tbl_op_q[1] ? wdata_q : lane_rdata;
						o_tbl_done  <= 1'b1;
						state_q     <= ST_IDLE;
					end else begin
						o_ds_rdata <= is_win_q ? lane_rdata : i_ram_rdata;
						if (xtra_q == `XTRA_NONE) begin
							o_ds_done <= 1'b1;
							state_q   <= ST_IDLE;
						end else begin
							state_q <= ST_XTRA;
						end
					end
				end
				ST_XTRA: begin
					// hold the core for the owed cycles
					xtra_q <= xtra_q - 2'h1;
					if (xtra_q == `XTRA_MOVE) begin
						o_ds_done <= 1'b1;
						state_q   <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // program_space_window
`default_nettype wire

// File: hw/psv_consts.vh
// constants for the program space window and table access block
// assumes inclusion by bare name from the block's design files
//
// Overview of operation
// - window hit needs ea top bit and enable
// - eight-bit window page picks one of 256
// - window address is page over low ea
// - low 15 ea bits map straight through
// - window reads stretched, two fetches needed (here one program memory read, then stall cycles)
// - window read returns low 16 bits only
// - table operations suspend the window
// - outside repeat: move one, others two extra
// - repeat edge iterations take two extra
// - other repeat iterations take no extra
// - self programming writes 32-instruction blocks
// - erase block size from two-bit field
// - table address is table page over ea
// - low table ops reach bits 15..0
// - high table ops reach bits 23..16
// - table ops work in normal mode
// - serial programming over clock/data lines
`ifndef PSV_CONSTS_VH
`define PSV_CONSTS_VH

// register byte offsets
`define OFS_CPU_CONTROL        8'h00
`define OFS_CONST_WINDOW_PAGE  8'h04
`define OFS_TABLE_PAGE         8'h08
`define OFS_MEM_PROG_CONTROL   8'h0C
`define OFS_STATUS             8'h10
`define OFS_PROG_SHIFT         8'h14

// field positions
`define BIT_WINDOW_ENABLE      2
`define BIT_ERASE_SEL_LO       0
`define BIT_STATUS_BUSY        0
`define BIT_STATUS_ERASE_LO    8
`define BIT_STATUS_WRITE_LO    16
`define BIT_EA_TOP             15

// reset values
`define RST_CPU_CONTROL        8'h00
`define RST_WINDOW_PAGE        8'h00
`define RST_TABLE_PAGE         8'h00
`define RST_ERASE_SEL          2'h0

// erase size encodings and block sizes in instructions and bytes
`define ERASE_SEL_32           2'h0
`define ERASE_SEL_64           2'h1
`define ERASE_SEL_128          2'h2
`define WRITE_BLOCK_INSTR      8'h20
`define WRITE_BLOCK_BYTES      8'h60
`define ERASE_BLOCK_32         8'h20
`define ERASE_BLOCK_64         8'h40
`define ERASE_BLOCK_128        8'h80

// extra instruction cycles
`define XTRA_NONE              2'h0
`define XTRA_MOVE              2'h1
`define XTRA_OTHER             2'h2

// table operation codes
`define TBL_READ_LOW           2'h0
`define TBL_READ_HIGH          2'h1
`define TBL_WRITE_LOW          2'h2
`define TBL_WRITE_HIGH         2'h3

`endif

// File: verif/mem_model.sv
// program memory and data ram stand-in facing the window block
// assumes both memories answer one cycle after a read pulse
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	// clock and read requests
	input  wire logic        i_clk_sys,
	input  wire logic        i_pm_rd,
	input  wire logic [23:0] i_pm_addr,
	input  wire logic        i_ram_rd,
	input  wire logic [15:0] i_ram_addr,
	// read data back to the block
	output var  logic [23:0] o_pm_rdata,
	output var  logic [15:0] o_ram_rdata
);
	initial begin
		o_pm_rdata = 24'h000000;
		o_ram_rdata = 16'h0000;
	end

	// data valid one cycle only; inverted after so a late capture shows up
	always @(posedge i_clk_sys) begin
		if (i_pm_rd)
			o_pm_rdata <= {{8{i_pm_addr[0]}}, i_pm_addr[15:0] ^ 16'h5A5A};
		else
			o_pm_rdata <= ~o_pm_rdata;
		if (i_ram_rd)
			o_ram_rdata <= i_ram_addr ^ 16'hC33C;
		else
			o_ram_rdata <= ~o_ram_rdata;
	end
endmodule // mem_model
`default_nettype wire

// File: verif/program_space_window_tb.sv
// self-checking bench for the program space window block
// assumes mem_model on the memory side and the bench as ahb and core
`timescale 1ns/1ps
`default_nettype none
`include "psv_consts.vh"
module program_space_window_tb;
	logic        i_clk_sys, i_rst_n, i_hsel, i_hwrite, o_hreadyout, o_hresp;
	logic [7:0]  i_haddr, o_write_block_instr, o_write_block_bytes, o_erase_block_instr;
	logic [1:0]  i_htrans, i_tbl_op;
	logic [2:0]  i_hsize, o_pm_wbe;
	logic [31:0] i_hwdata, o_hrdata;
	logic        i_ds_req, i_ds_is_move, i_rep_active, i_rep_first, i_rep_last;
	logic        i_rep_irq_exit, i_rep_irq_reentry, o_ds_ready, o_ds_done;
	logic        i_tbl_req, i_tbl_byte, i_normal_mode, o_tbl_ready, o_tbl_done;
	logic [15:0] i_ds_ea, o_ds_rdata, i_tbl_ea, i_tbl_wdata, o_tbl_rdata;
	logic        o_pm_rd, o_pm_wr, o_ram_rd, i_prog_clock_line, i_prog_data_line;
	logic [23:0] o_pm_addr, o_pm_wdata, i_pm_rdata;
	logic [15:0] o_ram_addr, i_ram_rdata;
	int          mismatches, samples_checked, cyc;

	program_space_window u_dut (.i_clk_sys, .i_rst_n, .i_hsel, .i_haddr, .i_htrans,
		.i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout, .o_hresp,
		.o_hrdata, .i_ds_req, .i_ds_ea, .i_ds_is_move, .i_rep_active, .i_rep_first,
		.i_rep_last, .i_rep_irq_exit, .i_rep_irq_reentry, .o_ds_ready, .o_ds_done,
		.o_ds_rdata, .i_tbl_req, .i_tbl_op, .i_tbl_byte, .i_tbl_ea, .i_tbl_wdata,
		.i_normal_mode, .o_tbl_ready, .o_tbl_done, .o_tbl_rdata, .o_pm_rd, .o_pm_wr,
		.o_pm_addr, .o_pm_wdata, .o_pm_wbe, .i_pm_rdata, .o_ram_rd, .o_ram_addr,
		.i_ram_rdata, .o_write_block_instr, .o_write_block_bytes, .o_erase_block_instr,
		.i_prog_clock_line, .i_prog_data_line, .o_prog_data_line(), .o_prog_data_line_oe());
	mem_model u_mem (.i_clk_sys, .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr),
		.i_ram_rd(o_ram_rd), .i_ram_addr(o_ram_addr), .o_pm_rdata(i_pm_rdata),
		.o_ram_rdata(i_ram_rdata));

	initial begin
		i_clk_sys = 0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	// hang guard, far above the fewer than two hundred cycles the run needs
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			wrap_up;
		end
	end

	task wrap_up;
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask

	// one single ahb transfer: address phase, then data phase
	task ahb(input [7:0] a, input w, input [31:0] wd, output [31:0] rd);
		i_hsel <= 1;
		i_haddr <= a;
		i_hwrite <= w;
		i_htrans <= 2'h2;
		do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
		i_hsel <= 0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
		rd = o_hrdata;
		chk("hresp", 0, o_hresp);
	endtask

	// one data-space read; rp is {reentry, exit, last, first, active}
	task ds(input [15:0] ea, input mv, input [4:0] rp, input win, input [1:0] ex);
		int n;
		logic pm, rm;
		logic [23:0] pa;
		n = 0;
		pm = 0;
		rm = 0;
		pa = 0;
		i_ds_req <= 1;
		i_ds_ea <= ea;
		i_ds_is_move <= mv;
		{i_rep_irq_reentry, i_rep_irq_exit, i_rep_last, i_rep_first, i_rep_active} <= rp;
		do @(posedge i_clk_sys); while (o_ds_ready !== 1'b1);
		i_ds_req <= 0;
		do begin
			@(posedge i_clk_sys);
			n++;
			if (o_pm_rd === 1'b1) begin
				pm = 1;
				pa = o_pm_addr;
			end
			if (o_ram_rd === 1'b1)
				rm = 1;
		end while (o_ds_done !== 1'b1 && n < 20);
		chk("ds_cycles", 3 + ex, n);
		chk("pm_used", win, pm);
		chk("ram_used", !win, rm);
		if (win) begin
			chk("win_addr", {1'b0, 8'hA5, ea[14:0]}, pa);
			chk("win_data", {1'b1, ea[14:0]} ^ 16'h5A5A, o_ds_rdata);
		end else
			chk("ram_data", ea ^ 16'hC33C, o_ds_rdata);
	endtask

	// one table access; page 3C; checks timing, address, lanes
	task tbl(input [1:0] op, input byt, input [15:0] ea, input [2:0] wbe);
		int n;
		logic wr;
		logic [2:0] be;
		logic [23:0] pa, wd;
		n = 0;
		wr = 0;
		be = 0;
		pa = 0;
		wd = 0;
		i_tbl_req <= 1;
		i_tbl_op <= op;
		i_tbl_byte <= byt;
		i_tbl_ea <= ea;
		i_tbl_wdata <= 16'hBEEF;
		do @(posedge i_clk_sys); while (o_tbl_ready !== 1'b1);
		chk("ds_ready", 0, o_ds_ready);
		i_tbl_req <= 0;
		do begin
			@(posedge i_clk_sys);
			n++;
			if ((o_pm_rd | o_pm_wr) === 1'b1) begin
				wr = o_pm_wr;
				pa = o_pm_addr;
				be = o_pm_wbe;
				wd = o_pm_wdata;
			end
		end while (o_tbl_done !== 1'b1 && n < 20);
		chk("tbl_cycles", 3, n);
		chk("tbl_addr", {8'h3C, ea}, pa);
		chk("tbl_dir", op[1], wr);
		if (op == `TBL_READ_LOW && !byt)
			chk("rd_low", ea ^ 16'h5A5A, o_tbl_rdata);
		if (op == `TBL_READ_HIGH && !byt)
			chk("rd_high", {8'h00, {8{ea[0]}}}, o_tbl_rdata);
		if (op == `TBL_READ_LOW && byt)
			chk("rd_lb", {8'h00, (ea[0] ? ea[15:8] : ea[7:0]) ^ 8'h5A}, o_tbl_rdata);
		if (op == `TBL_READ_HIGH && byt)
			chk("rd_hb", ea[0] ? 16'h0000 : 16'h0000, o_tbl_rdata);
		if (op[1])
			chk("wbe", wbe, be);
		if (op == `TBL_WRITE_LOW && !byt)
			chk("wr_low", 16'hBEEF, wd[15:0]);
		if (op == `TBL_WRITE_HIGH && !byt)
			chk("wr_high", 8'hEF, wd[23:16]);
	endtask

	task reg_scen;
		logic [31:0] r;
		chk("erase_rst", 8'h20, o_erase_block_instr);
		chk("wr_block", 16'h6020, {o_write_block_bytes, o_write_block_instr});
		ahb(`OFS_CONST_WINDOW_PAGE, 1, 32'hA5, r);
		ahb(`OFS_CONST_WINDOW_PAGE, 0, 0, r);
		chk("page_rd", 32'hA5, r);
		ahb(`OFS_TABLE_PAGE, 1, 32'h3C, r);
		ahb(`OFS_TABLE_PAGE, 0, 0, r);
		chk("tpage_rd", 32'h3C, r);
		ahb(8'h1C, 1, 32'hFF, r);
		ahb(8'h1C, 0, 0, r);
		chk("unmapped", 0, r);
	endtask

	task erase_scen;
		logic [31:0] r;
		logic [7:0] sz [4];
		sz = '{8'h20, 8'h40, 8'h80, 8'h20};
		for (int s = 0; s < 4; s++) begin
			ahb(`OFS_MEM_PROG_CONTROL, 1, s, r);
			repeat (2) @(posedge i_clk_sys);
			chk("erase_size", sz[s], o_erase_block_instr);
		end
	endtask

	task window_scen;
		logic [31:0] r;
		ahb(`OFS_CPU_CONTROL, 1, 32'h4, r);
		ds(16'h1234, 0, 5'h00, 0, 0);
		ds(16'h8001, 0, 5'h00, 1, 2);
		ds(16'hFFFE, 1, 5'h00, 1, 1);
		ds(16'h8ABC, 0, 5'h01, 1, 0);
		for (int i = 1; i < 5; i++)
			ds(16'h8C35, 0, 5'h01 | 5'(1 << i), 1, 2);
		ahb(`OFS_CPU_CONTROL, 1, 32'h0, r);
		ds(16'h8123, 0, 5'h00, 0, 0);
	endtask

	task table_scen;
		tbl(`TBL_READ_LOW, 0, 16'h2468, 3'h0);
		tbl(`TBL_READ_HIGH, 0, 16'h1235, 3'h0);
		tbl(`TBL_READ_LOW, 1, 16'h0011, 3'h0);
		tbl(`TBL_READ_HIGH, 1, 16'h1235, 3'h0);
		tbl(`TBL_WRITE_LOW, 0, 16'h0040, 3'h3);
		tbl(`TBL_WRITE_LOW, 1, 16'h0040, 3'h1);
		tbl(`TBL_WRITE_LOW, 1, 16'h0041, 3'h2);
		tbl(`TBL_WRITE_HIGH, 0, 16'h0042, 3'h4);
		tbl(`TBL_WRITE_HIGH, 1, 16'h0043, 3'h0);
		i_normal_mode <= 0;
		repeat (2) @(posedge i_clk_sys);
		chk("tbl_ready", 0, o_tbl_ready);
		i_normal_mode <= 1;
		@(posedge i_clk_sys);
	endtask

	// sixteen serial clock rises, msb first, then the shift and status words
	task prog_scen;
		logic [31:0] r;
		logic [15:0] p;
		p = 16'hC3A5;
		for (int b = 15; b >= 0; b--) begin
			i_prog_data_line <= p[b];
			i_prog_clock_line <= 1;
			@(posedge i_clk_sys);
			i_prog_clock_line <= 0;
			@(posedge i_clk_sys);
		end
		ahb(`OFS_PROG_SHIFT, 0, 0, r);
		chk("prog_shift", 32'hC3A5, r);
		ahb(`OFS_STATUS, 0, 0, r);
		chk("status", 32'h00202000, r);
	endtask

	initial begin
		{i_rst_n, i_hsel, i_hwrite, i_haddr, i_htrans, i_hwdata, i_tbl_op} = 0;
		{i_ds_req, i_ds_is_move, i_rep_active, i_rep_first, i_rep_last} = 0;
		{i_rep_irq_exit, i_rep_irq_reentry, i_tbl_req, i_tbl_byte, i_ds_ea} = 0;
		{i_tbl_ea, i_tbl_wdata, i_prog_clock_line, i_prog_data_line} = 0;
		i_hsize = 3'h2;
		i_normal_mode = 1;
		mismatches = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1;
		@(posedge i_clk_sys);
		reg_scen;
		erase_scen;
		window_scen;
		table_scen;
		prog_scen;
		wrap_up;
	end
endmodule // program_space_window_tb
`default_nettype wire

// File: verif/psw_monitor.sv
// timing and routing checks for the program space window block
// assumes binding onto program_space_window, one clock domain
`timescale 1ns/1ps
`default_nettype none
module psw_monitor (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic        i_ds_req,
	input wire logic [15:0] i_ds_ea,
	input wire logic        i_ds_is_move,
	input wire logic        i_rep_active,
	input wire logic        i_rep_first,
	input wire logic        i_rep_last,
	input wire logic        i_rep_irq_exit,
	input wire logic        i_rep_irq_reentry,
	input wire logic        o_ds_ready,
	input wire logic        o_ds_done,
	input wire logic        i_tbl_req,
	input wire logic [15:0] i_tbl_ea,
	input wire logic        i_normal_mode,
	input wire logic        o_tbl_ready,
	input wire logic        o_tbl_done,
	input wire logic        o_pm_rd,
	input wire logic        o_pm_wr,
	input wire logic [23:0] o_pm_addr,
	input wire logic        o_ram_rd,
	input wire logic [15:0] o_ram_addr,
	input wire logic [7:0]  o_write_block_instr,
	input wire logic [7:0]  o_write_block_bytes,
	input wire logic [7:0]  o_erase_block_instr
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic [15:0] ea_q; // address of the last taken request
	wire ds_take = i_ds_req & o_ds_ready;
	wire tb_take = i_tbl_req & o_tbl_ready;
	wire rep_edge = i_rep_first | i_rep_last | i_rep_irq_exit | i_rep_irq_reentry;

	// keep the taken address so the issue cycle can be compared to it
	always @(posedge i_clk_sys) begin
		if (tb_take)
			ea_q <= i_tbl_ea;
		else if (ds_take)
			ea_q <= i_ds_ea;
	end

	// done lands on the third edge from where the sequence starts
	sequence lat3;
		!o_ds_done ##1 !o_ds_done ##1 o_ds_done;
	endsequence

	write_block_a: assert property (
		o_write_block_instr == 8'h20 && o_write_block_bytes == 8'h60) else $error("write size");
	erase_size_a: assert property (
		o_erase_block_instr inside {8'h20, 8'h40, 8'h80}) else $error("erase size");
	tbl_suspend_a: assert property (
		i_tbl_req |-> !o_ds_ready) else $error("window open in table op");
	ram_route_a: assert property (
		ds_take && !i_ds_ea[15] |=> o_ram_rd && !o_pm_rd && o_ram_addr == ea_q ##0 lat3)
		else $error("ram access wrong");
	win_addr_a: assert property (
		ds_take ##1 o_pm_rd |-> ea_q[15] && !o_pm_addr[23] && o_pm_addr[14:0] == ea_q[14:0])
		else $error("window address");
	move_extra_a: assert property (
		ds_take && i_ds_is_move && !i_rep_active ##1 o_pm_rd |=> lat3) else $error("move stall");
	other_extra_a: assert property (
		ds_take && !i_ds_is_move && !i_rep_active ##1 o_pm_rd |=> !o_ds_done ##1 lat3)
		else $error("other stall");
	rep_edge_a: assert property (
		ds_take && i_rep_active && rep_edge ##1 o_pm_rd |=> !o_ds_done ##1 lat3)
		else $error("repeat edge stall");
	rep_mid_a: assert property (
		ds_take && i_rep_active && !rep_edge |=> lat3) else $error("repeat middle stall");
	tbl_addr_a: assert property (
		tb_take |=> (o_pm_rd ^ o_pm_wr) && o_pm_addr[15:0] == ea_q) else $error("table address");
	tbl_mode_a: assert property (
		!i_normal_mode |-> !o_tbl_ready) else $error("table outside normal mode");
	tbl_lat_a: assert property (
		tb_take |=> !o_tbl_done ##1 !o_tbl_done ##1 o_tbl_done) else $error("table timing");

	cover property (ds_take && i_ds_ea[15]);
	cover property (ds_take && i_rep_active);
	cover property (tb_take);
endmodule // psw_monitor

bind program_space_window psw_monitor u_mon (.i_clk_sys, .i_rst_n, .i_ds_req, .i_ds_ea,
	.i_ds_is_move, .i_rep_active, .i_rep_first, .i_rep_last, .i_rep_irq_exit,
	.i_rep_irq_reentry, .o_ds_ready, .o_ds_done, .i_tbl_req, .i_tbl_ea, .i_normal_mode,
	.o_tbl_ready, .o_tbl_done, .o_pm_rd, .o_pm_wr, .o_pm_addr, .o_ram_rd, .o_ram_addr,
	.o_write_block_instr, .o_write_block_bytes, .o_erase_block_instr);
`default_nettype wire
